/* adc_input_ref_select.sv */
`timescale 1ns/1ps
`default_nettype none
// Operation
// RULE1: codes 0 to 26 route external channel n to the positive input.
// RULE2: codes 27,28,29 route temperature sensor, supply, regulator output.
// RULE3: code 31 connects ground; code 30 and reserved connect nothing.
// RULE4: software clears pin mux registers when an internal source is chosen.
// RULE5: reference field bits 4:3 pick pin, supply, 1.8 V, 1.65 V.
// RULE6: reference control bit 2 enables the temperature sensor.
// RULE7: software writes reset value into reserved reference control bits.
// RULE8: offset-high register reads top eight bits of factory offset.
// RULE9: new selections drive switches from the edge after the write.
module adc_input_ref_select
   import adc_sel_pkg::*;
#(
   parameter int N_EXT = NUM_EXT
)(
   input  wire logic             i_clk,          // Core clock
   input  wire logic             i_rst_n,        // Async reset, active low
   input  wire sfr_req_t         i_req,          // Register write/read request
   output logic      [7:0]       o_rdata,        // Registered read data
   input  wire logic [9:0]       i_temp_offset,  // Factory offset, fixed after trim
   output logic      [N_EXT-1:0] o_ext_sel,      // External channel switches
   output var int_src_t          o_int_sel,      // Internal source switches
   output logic      [3:0]       o_ref_en,       // Reference switches
   output logic                  o_temp_sensor_enable // Sensor power
);
   // ==========================================
   // Registers
   logic [7:0] reference_control_r;
   logic [7:0] reference_control_nxt;
   logic [4:0] positive_input_select_r;
   logic [4:0] positive_input_select_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic [7:0] temp_offset_value_meta_r;
   logic [7:0] temp_offset_value_sync_r;
   logic [7:0] temp_offset_value_meta_nxt;
   logic [7:0] temp_offset_value_sync_nxt;

   // ==========================================
   // Offset synchroniser
   // Trim value comes from outside the core clock domain; two stages before use
   always_comb begin
      temp_offset_value_meta_nxt = i_temp_offset[9:2];
      temp_offset_value_sync_nxt = temp_offset_value_meta_r;
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         temp_offset_value_meta_r <= 8'h00;
         temp_offset_value_sync_r <= 8'h00;
      end else begin
         temp_offset_value_meta_r <= temp_offset_value_meta_nxt;
         temp_offset_value_sync_r <= temp_offset_value_sync_nxt;
      end
   end

   always_comb begin
      reference_control_nxt     = reference_control_r;
      positive_input_select_nxt = positive_input_select_r;
      rdata_nxt                 = rdata_r;
      // RULE9: write takes effect
      if (i_req.wr) begin
         // Reserved bits stored as written; software keeps them at reset value
         if (i_req.addr == REFERENCE_CONTROL_ADDR)
            reference_control_nxt = i_req.wdata;
         if (i_req.addr == CONVERTER_INPUT_SELECT_ADDR)
            positive_input_select_nxt = i_req.wdata[SEL_MSB:0];
      end
      if (i_req.rd) begin
         case (i_req.addr)
            REFERENCE_CONTROL_ADDR:      rdata_nxt = reference_control_r;
            CONVERTER_INPUT_SELECT_ADDR: rdata_nxt = {3'h0, positive_input_select_r};
            // RULE8: offset high byte
            TEMP_OFFSET_HIGH_ADDR:       rdata_nxt = temp_offset_value_sync_r;
            default:                     rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         reference_control_r     <= REFERENCE_CONTROL_RST;
         positive_input_select_r <= CONVERTER_INPUT_SELECT_RST[SEL_MSB:0];
         rdata_r                 <= 8'h00;
      end else begin
         reference_control_r     <= reference_control_nxt;
         positive_input_select_r <= positive_input_select_nxt;
         rdata_r                 <= rdata_nxt;
      end
   end

   assign o_rdata = rdata_r;

   // ==========================================
   // Input switch decode, straight from the register
   // RULE1: external channels
   genvar g;
   generate
      for (g = 0; g < N_EXT; g++) begin : g_ext
         assign o_ext_sel[g] = (positive_input_select_r == 5'(g)) &&
                               (positive_input_select_r <= SEL_LAST_EXT);
      end
   endgenerate

   // RULE2: internal sources
   // RULE3: ground, reserved open
   // One driver for the whole struct; code 30 matches no field
   assign o_int_sel = '{temp_sensor: (positive_input_select_r == SEL_TEMP),
                        supply:      (positive_input_select_r == SEL_SUPPLY),
                        reg_out:     (positive_input_select_r == SEL_REG_OUT),
                        ground:      (positive_input_select_r == SEL_GROUND)};

   // ==========================================
   // Reference and sensor
   ref_decode u_ref (
      .i_sel    (reference_control_r[REF_MSB:REF_LSB]),
      .o_ref_en (o_ref_en)
   );

   // RULE6: sensor enable
   assign o_temp_sensor_enable = reference_control_r[TEMP_BIT];
endmodule
`default_nettype wire

/* adc_sel_pkg.sv */
package adc_sel_pkg;
   // ==========================================
   // Register map (special-function addresses)
   localparam logic [7:0] REFERENCE_CONTROL_ADDR      = 8'hd1;
   localparam logic [7:0] CONVERTER_INPUT_SELECT_ADDR = 8'hd4;
   localparam logic [7:0] TEMP_OFFSET_HIGH_ADDR       = 8'hd5;

   // ==========================================
   // Field layout
   localparam int SEL_MSB  = 4;
   localparam int REF_MSB  = 4;
   localparam int REF_LSB  = 3;
   localparam int TEMP_BIT = 2;

   // ==========================================
   // Reset values
   localparam logic [7:0] REFERENCE_CONTROL_RST      = 8'h00;
   localparam logic [7:0] CONVERTER_INPUT_SELECT_RST = 8'h1f;

   // ==========================================
   // Input select codes
   localparam logic [4:0] SEL_LAST_EXT = 5'h1a;
   localparam logic [4:0] SEL_TEMP     = 5'h1b;
   localparam logic [4:0] SEL_SUPPLY   = 5'h1c;
   localparam logic [4:0] SEL_REG_OUT  = 5'h1d;
   localparam logic [4:0] SEL_GROUND   = 5'h1f;
   localparam int         NUM_EXT      = 27;

   typedef enum logic [1:0] {
      REF_EXT_PIN  = 2'b00,
      REF_SUPPLY   = 2'b01,
      REF_DIG_1V8  = 2'b10,
      REF_INT_1V65 = 2'b11
   } ref_sel_t;

   typedef struct packed {
      logic       temp_sensor;
      logic       supply;
      logic       reg_out;
      logic       ground;
   } int_src_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_req_t;
endpackage

/* adc_sel_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_sel_checker
   import adc_sel_pkg::*;
#(parameter int N_EXT = NUM_EXT)(
   input wire logic             i_clk,
   input wire logic             i_rst_n,
   input wire sfr_req_t         i_req,
   input wire logic [7:0]       o_rdata,
   input wire logic [9:0]       i_temp_offset,
   input wire logic [N_EXT-1:0] o_ext_sel,
   input wire int_src_t         o_int_sel,
   input wire logic [3:0]       o_ref_en,
   input wire logic             o_temp_sensor_enable
);
   // ==========================
   // Write decode
   wire logic       wsel = i_req.wr && i_req.addr == 8'hd4;
   wire logic       wref = i_req.wr && i_req.addr == 8'hd1;
   wire logic [4:0] c    = i_req.wdata[4:0];
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   a_ext_route: assert property (wsel && c < N_EXT |=> o_ext_sel == 1 << $past(c))
      else $error("ext route");
   a_int_route: assert property (wsel && c inside {[27:29]} |=> o_int_sel == 4'h8 >> ($past(c) - 27))
      else $error("int route");
   a_gnd_none: assert property (wsel && c > 29 |=> o_ext_sel == 0 && o_int_sel == {3'h0, $past(c[0])})
      else $error("gnd route");
   a_ref_route: assert property (wref |=> o_ref_en == 4'h1 << $past(i_req.wdata[4:3]))
      else $error("ref route");
   a_temp_en: assert property (wref |=> o_temp_sensor_enable == $past(i_req.wdata[2]))
      else $error("temp enable");
   a_off_read: assert property (i_req.rd && i_req.addr == 8'hd5 |=> o_rdata == $past(i_temp_offset[9:2]))
      else $error("offset read");
   a_sel_hold: assert property (!i_req.wr |=> $stable(o_ext_sel) && $stable(o_ref_en))
      else $error("switch hold");
   a_rd_hold: assert property (!i_req.rd |=> $stable(o_rdata))
      else $error("rdata hold");
endmodule
bind adc_input_ref_select adc_sel_checker #(.N_EXT(N_EXT)) u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
   .i_req(i_req), .o_rdata(o_rdata), .i_temp_offset(i_temp_offset), .o_ext_sel(o_ext_sel),
   .o_int_sel(o_int_sel), .o_ref_en(o_ref_en), .o_temp_sensor_enable(o_temp_sensor_enable));
`default_nettype wire

/* ref_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module ref_decode
   import adc_sel_pkg::*;
(
   input  wire logic [1:0] i_sel,     // Reference select code
   output logic      [3:0] o_ref_en   // One-hot reference switch enables
);
   // RULE5: reference one-hot
   always_comb begin
      o_ref_en = 4'h0;
      case (ref_sel_t'(i_sel))
         REF_EXT_PIN:  o_ref_en = 4'h1;
         REF_SUPPLY:   o_ref_en = 4'h2;
         REF_DIG_1V8:  o_ref_en = 4'h4;
         REF_INT_1V65: o_ref_en = 4'h8;
         default:      o_ref_en = 4'h0;
      endcase
   end
endmodule
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
   import adc_sel_pkg::*;
   logic       i_clk = 0, i_rst_n = 0, ten;
   sfr_req_t   req = '0;
   logic [9:0] temp_offset_value = 10'h2b5;
   logic [7:0] rdata;
   logic [3:0] ref_en;
   logic [26:0] ext;
   int_src_t   isel;
   int         n_fail = 0, check_count = 0, cyc = 0;
   always #20 i_clk = ~i_clk;
   // Ceiling well above the roughly 120 cycles of traffic
   always @(posedge i_clk) if (++cyc > 5000) begin n_fail++; complete_run(); end
   adc_input_ref_select u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(req), .o_rdata(rdata),
      .i_temp_offset(temp_offset_value), .o_ext_sel(ext), .o_int_sel(isel), .o_ref_en(ref_en),
      .o_temp_sensor_enable(ten));
   // ==========================
   // Shared tasks
   task chk(input string nm, input logic [31:0] e, g);
      check_count++;
      if (g !== e) begin n_fail++; $display("wrong value %s exp %h got %h", nm, e, g); end
   endtask
   task acc(input logic w, input logic [7:0] a, d);
      req = '{wr: w, rd: !w, addr: a, wdata: d};
      @(negedge i_clk);
      req = '0;
      @(negedge i_clk);
   endtask
   task t_sel;
      // pin mux registers live outside this block and stay cleared
      for (int c = 0; c < 32; c++) begin
         acc(1, 8'hd4, 8'(c));
         chk("ext", c < 27 ? 32'h1 << c : 0, ext);
         chk("int", c inside {[27:29]} ? 32'h8 >> (c - 27) : 32'(c == 31), isel);
      end
      acc(0, 8'hd4, 0);
      chk("sel rd", 8'h1f, rdata);
   endtask
   task t_ref;
      for (int r = 0; r < 8; r++) begin
         acc(1, 8'hd1, 8'(r << 2));
         chk("ref", 32'h1 << r[2:1], ref_en);
         chk("temp", r[0], ten);
      end
      acc(0, 8'hd1, 0);
      chk("ref rd", 8'h1c, rdata);
   endtask
   task t_off;
      acc(1, 8'hd5, 8'h00);
      acc(0, 8'hd5, 0);
      chk("offset", temp_offset_value[9:2], rdata);
      acc(0, 8'h00, 0);
      chk("unmapped", 0, rdata);
   endtask
   task t_rst;
      acc(1, 8'hd1, 8'h1c);
      acc(1, 8'hd4, 8'h03);
      acc(0, 8'hd5, 0);
      i_rst_n = 0;
      @(negedge i_clk);
      chk("rdata rst", 0, rdata);
      chk("ref rst2", 4'h1, ref_en);
      chk("temp rst", 0, ten);
      chk("ext rst", 0, ext);
      chk("gnd rst2", 4'h1, isel);
      i_rst_n = 1;
      repeat (2) @(negedge i_clk);
   endtask
   task complete_run;
      $display("checks %0d fails %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (20) @(negedge i_clk);
      i_rst_n = 1;
      chk("ref rst", 4'h1, ref_en);
      chk("gnd rst", 4'h1, isel);
      t_ref();
      t_sel();
      t_off();
      t_rst();
      t_off();
      complete_run();
   end
endmodule
`default_nettype wire
